// ===== logic/pnpcf_config_loader.sv
// Configuration mode decode, power-up loader, vendor indices and key detect
`timescale 1ns/1ps
module pnpcf_config_loader (
   // Clock and reset (reset doubles as RSTDRV)
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // Avalon-MM slave
   input  wire logic [9:0]  avsAddress,
   input  wire logic        avsRead,
   input  wire logic        avsWrite,
   input  wire logic [31:0] avsWritedata,
   output logic      [31:0] avsReaddata,
   output logic             avsWaitrequest,
   // Strap pins
   input  wire logic        jumperStrap,
   input  wire logic        plugPlayStrap,
   input  wire logic [6:0]  jumperCfg1,
   input  wire logic [7:0]  jumperCfg2,
   // EEPROM image
   input  wire logic        eepromPlugPlayFlag,
   input  wire logic [6:0]  eepromCfg1,
   input  wire logic [7:0]  eepromCfg2,
   input  wire logic [6:0]  eepromCfg3,
   // Configuration state
   output logic [7:0]       cfg0,
   output logic [7:0]       cfg1,
   output logic [7:0]       cfg2,
   output logic [7:0]       cfg3,
   output logic [7:0]       cardSelectNumber,
   output logic [7:0]       savedCardNumber,
   output logic             deviceActive,
   output pnpcf_pkg::pnpcf_state_t pnpState,
   output pnpcf_pkg::pnpcf_mode_t  configMode,
   output logic             portsEnabled
);
   import pnpcf_pkg::*;

   // ==========================================================================
   // Bus handshake
   // One wait cycle per request: readdata is loaded at the first edge and
   // stands while waitrequest is low, so a read has no race with writes.
   wire logic       busReq    = avsRead || avsWrite;
   wire logic       commit    = busReq && !avsWaitrequest;
   wire logic [7:0] regIndex  = avsAddress[9:2];
   wire logic [7:0] wrByte    = avsWritedata[7:0];
   wire logic       wrCommit  = commit && avsWrite;
   wire logic       next_avsWaitrequest = !(busReq && avsWaitrequest);

   // ==========================================================================
   // State qualifiers
   // Ports stay quiescent until a key has been seen
   wire logic cfgOn  = (pnpState == ST_CONFIG);
   wire logic pnpOn  = (pnpState != ST_WAIT_KEY);
   wire logic isPnp  = (configMode == MODE_PNP);

   // Write strobes per index
   wire logic wrKey     = wrCommit && (regIndex == IDX_KEY_PORT);
   wire logic wrCommand = wrCommit && (regIndex == IDX_COMMAND);
   wire logic wrCfgCtl  = wrCommit && pnpOn && (regIndex == IDX_CFG_CTRL);
   wire logic wrWake    = wrCommit && pnpOn && (regIndex == IDX_WAKE);
   wire logic wrCsn     = wrCommit && (pnpState == ST_ISOLATE || cfgOn)
                          && (regIndex == IDX_CSN);
   wire logic wrActive  = wrCommit && cfgOn && (regIndex == IDX_ACTIVATE);
   wire logic wrIoHi    = wrCommit && cfgOn && (regIndex == IDX_IO_BASE_HI);
   wire logic wrIoLo    = wrCommit && cfgOn && (regIndex == IDX_IO_BASE_LO);
   wire logic wrIrq     = wrCommit && cfgOn && (regIndex == IDX_IRQ_LEVEL);
   wire logic wrVendor  = wrCommit && cfgOn && (regIndex == IDX_VENDOR_CTL);

   // Command bits
   wire logic autoloadCmd = wrCommand && wrByte[CMD_AUTOLOAD_BIT];
   wire logic waitKeyCmd  = wrCfgCtl && wrByte[CCTL_WAIT_KEY];
   wire logic resetCsnCmd = wrCfgCtl && wrByte[CCTL_RESET_CSN];

   // ==========================================================================
   // Key detection
   logic stdMatch;
   logic vendorMatch;

   // Standard key counts only in plug-and-play mode
   pnpcf_key_match #(.KEY(STD_KEY)) u_std_key (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .enable    (isPnp),
      .keyStrobe (wrKey),
      .keyData   (wrByte),
      .matched   (stdMatch)
   );

   // Vendor key counts in every mode
   pnpcf_key_match #(.KEY(VENDOR_KEY)) u_vendor_key (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .enable    (1'b1),
      .keyStrobe (wrKey),
      .keyData   (wrByte),
      .matched   (vendorMatch)
   );

   wire logic keyFound = stdMatch || vendorMatch;

   // ==========================================================================
   // Power-up load sources
   // Mode is taken from the straps and EEPROM flag each time a load runs
   logic        loadPending;
   pnpcf_mode_t loadMode;
   always_comb begin
      if (jumperStrap) begin
         loadMode = MODE_JUMPER;
      end else if (plugPlayStrap || eepromPlugPlayFlag) begin
         loadMode = MODE_PNP;
      end else begin
         loadMode = MODE_EEPROM;
      end
   end

   // Straps feed jumper mode, the EEPROM image the other two
   wire logic       fromPins  = (loadMode == MODE_JUMPER);
   wire logic       loadIsPnp = (loadMode == MODE_PNP);
   wire logic [6:0] srcCfg1   = fromPins ? jumperCfg1 : eepromCfg1;
   wire logic [7:0] srcCfg2   = fromPins ? jumperCfg2 : eepromCfg2;
   wire logic       loadActiveb = loadIsPnp && eepromCfg3[CFG3_INACTIVE_AT_POWERUP_BIT_BIT];

   // Reload values of cfg1-cfg3
   logic [7:0] loadCfg1;
   logic [7:0] loadCfg2;
   logic [7:0] loadCfg3;
   always_comb begin
      loadCfg1 = {1'b0, srcCfg1};
      loadCfg1[CFG1_INTERRUPT_OUTPUT_ENABLE_BIT] = !loadIsPnp;
      loadCfg2 = srcCfg2;
      loadCfg2[CFG2_BOOT_ROM_DISABLE_BIT] = 1'b0;
      loadCfg3 = {1'b0, eepromCfg3};
      loadCfg3[CFG3_PNP_BIT]     = loadIsPnp;
      loadCfg3[3]                = 1'b0;
      loadCfg3[CFG3_SLEEP_BIT]   = 1'b0;
      loadCfg3[CFG3_INACTIVE_AT_POWERUP_BIT_BIT] = loadActiveb;
   end

   // ==========================================================================
   // Logical-device registers and their cfg mirrors
   logic [7:0] ioBaseHi;
   logic [7:0] ioBaseLo;
   logic [3:0] irqLevel;
   logic       clearPulse;
   wire  logic [7:0] ioHiNew  = wrByte & IO_HI_MASK;
   wire  logic [7:0] ioLoNew  = wrByte & IO_LO_MASK;
   wire  logic [3:0] ioCodeHi = {ioHiNew[0], ioBaseLo[7:5]};
   wire  logic [3:0] ioCodeLo = {ioBaseHi[0], ioLoNew[7:5]};

   // Next cfg1 and cfg3; cfg2 holds boot ROM size and is never written here
   logic [7:0] next_cfg1;
   logic [7:0] next_cfg3;
   always_comb begin
      next_cfg1 = cfg1;
      next_cfg3 = cfg3;
      if (loadPending) begin
         next_cfg1 = loadCfg1;
         next_cfg3 = loadCfg3;
      end else begin
         if (wrIrq) begin
            next_cfg1[6:4] = wrByte[2:0];
         end
         if (wrIoHi) begin
            next_cfg1[3:0] = ioCodeHi;
         end
         if (wrIoLo) begin
            next_cfg1[3:0] = ioCodeLo;
         end
         if (wrActive && isPnp) begin
            next_cfg3[CFG3_INACTIVE_AT_POWERUP_BIT_BIT] = !wrByte[0];
         end
      end
   end

   // ==========================================================================
   // Card state machine
   pnpcf_state_t next_pnpState;
   always_comb begin
      next_pnpState = pnpState;
      case (pnpState)
         ST_WAIT_KEY: begin
            if (keyFound) begin
               next_pnpState = ST_SLEEP;
            end
         end
         ST_SLEEP, ST_ISOLATE, ST_CONFIG: begin
            if (wrWake && wrByte == cardSelectNumber) begin
               next_pnpState = (wrByte == ZERO_BYTE) ? ST_ISOLATE : ST_CONFIG;
            end else if (wrWake) begin
               next_pnpState = ST_SLEEP;
            end else if (wrCsn) begin
               next_pnpState = ST_CONFIG;
            end
            if (waitKeyCmd) begin
               next_pnpState = ST_WAIT_KEY;
            end
         end
         default: begin
            next_pnpState = ST_WAIT_KEY;
         end
      endcase
   end

   // Live card number: writes set it, both clears zero it
   logic [7:0] next_cardSelectNumber;
   always_comb begin
      next_cardSelectNumber = cardSelectNumber;
      if (wrCsn) begin
         next_cardSelectNumber = wrByte;
      end
      if (clearPulse || resetCsnCmd) begin
         next_cardSelectNumber = ZERO_BYTE;
      end
   end

   // ==========================================================================
   // Read mux; unmapped, write-only and gated indices read zero
   logic [7:0] rdByte;
   always_comb begin
      rdByte = ZERO_BYTE;
      case (regIndex)
         IDX_CSN:        rdByte = cfgOn ? cardSelectNumber : ZERO_BYTE;
         IDX_ACTIVATE:   rdByte = cfgOn ? {7'h00, deviceActive} : ZERO_BYTE;
         IDX_IO_BASE_HI: rdByte = cfgOn ? ioBaseHi : ZERO_BYTE;
         IDX_IO_BASE_LO: rdByte = cfgOn ? ioBaseLo : ZERO_BYTE;
         IDX_IRQ_LEVEL:  rdByte = cfgOn ? {4'h0, irqLevel} : ZERO_BYTE;
         IDX_DMA_SEL0:   rdByte = cfgOn ? DMA_NONE_VALUE : ZERO_BYTE;
         IDX_DMA_SEL1:   rdByte = cfgOn ? DMA_NONE_VALUE : ZERO_BYTE;
         IDX_CFG0:       rdByte = cfgOn ? cfg0 : ZERO_BYTE;
         IDX_CFG1:       rdByte = cfgOn ? cfg1 : ZERO_BYTE;
         IDX_CFG2:       rdByte = cfgOn ? cfg2 : ZERO_BYTE;
         IDX_CFG3:       rdByte = cfgOn ? cfg3 : ZERO_BYTE;
         IDX_UNUSED_F4:  rdByte = ZERO_BYTE;
         IDX_SAVED_CSN:  rdByte = cfgOn ? savedCardNumber : ZERO_BYTE;
         IDX_STATUS:     rdByte = {2'b00, loadPending, deviceActive,
                                   configMode, pnpState};
         default:        rdByte = ZERO_BYTE;
      endcase
   end

   // ==========================================================================
   // Bus registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         avsWaitrequest <= 1'b1;
         avsReaddata    <= 32'h0000_0000;
      end else begin
         avsWaitrequest <= next_avsWaitrequest;
         if (busReq && avsWaitrequest) begin
            avsReaddata <= {24'h00_0000, rdByte};
         end
      end
   end

   // Load request: reset leaves one pending, auto-load raises another
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         loadPending <= 1'b1;
      end else begin
         loadPending <= autoloadCmd;
      end
   end

   // cfg0 follows the strap pins every cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg0 <= ZERO_BYTE;
      end else begin
         cfg0 <= ZERO_BYTE;
         cfg0[CFG0_JP_BIT]    <= jumperStrap;
         cfg0[CFG0_PLUG_PLAY_STRAP_BIT] <= plugPlayStrap;
      end
   end

   // Config registers; cfg2 changes only on a load
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg1       <= ZERO_BYTE;
         cfg2       <= ZERO_BYTE;
         cfg3       <= ZERO_BYTE;
         configMode <= MODE_JUMPER;
      end else begin
         cfg1 <= next_cfg1;
         cfg3 <= next_cfg3;
         if (loadPending) begin
            cfg2       <= loadCfg2;
            configMode <= loadMode;
         end
      end
   end

   // Logical-device registers, reloaded with the defaults
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ioBaseHi     <= ZERO_BYTE;
         ioBaseLo     <= ZERO_BYTE;
         irqLevel     <= 4'h0;
         deviceActive <= 1'b0;
      end else if (loadPending) begin
         ioBaseHi     <= {7'h00, loadCfg1[3]};
         ioBaseLo     <= {loadCfg1[2:0], 5'h00};
         irqLevel     <= {1'b0, loadCfg1[6:4]};
         deviceActive <= !loadActiveb;
      end else begin
         if (wrIoHi) begin
            ioBaseHi <= ioHiNew;
         end
         if (wrIoLo) begin
            ioBaseLo <= ioLoNew;
         end
         if (wrIrq) begin
            irqLevel <= wrByte[3:0];
         end
         if (wrActive) begin
            deviceActive <= wrByte[0];
         end
      end
   end

   // Card state, card numbers and the self-clearing vendor clear bit
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pnpState         <= ST_WAIT_KEY;
         cardSelectNumber <= ZERO_BYTE;
         savedCardNumber  <= ZERO_BYTE;
         clearPulse       <= 1'b0;
         portsEnabled     <= 1'b0;
      end else begin
         pnpState         <= next_pnpState;
         cardSelectNumber <= next_cardSelectNumber;
         if (wrCsn) begin
            savedCardNumber <= wrByte;
         end
         clearPulse   <= wrVendor && wrByte[VCTL_CLEAR_BIT];
         portsEnabled <= (next_pnpState != ST_WAIT_KEY);
      end
   end

endmodule // pnpcf_config_loader

// ===== logic/pnpcf_pkg.sv
// Package of constants, types and key tables for the configuration loader
// ==========================================================================
// Overview of operation
// - DMA select indices read 04h in config state
// - Indices F0h-F3h mirror cfg0-cfg3 live
// - Index F5h mirrors saved card number
// - F6h bit 2 clears live card number
// - Clear bit self-clears, saved copy untouched
// - Mode from two straps and EEPROM flag
// - cfg0 shows straps; cfg3 flags per mode
// - Power-up settings from straps or EEPROM
// - Software config writes also update cfg1, and cfg3 in PnP mode only
// - Auto-load or RSTDRV reloads defaults
// - Boot ROM size never software writable
// - Vendor key always; standard key PnP only
// - Vendor key reaches sleep state any mode
// - EEPROM mode powers up active
// - Quiescent until 32-byte key written
// - Key mismatch restarts key progress
// - Fixed standard and vendor key bytes
// - Reload values of cfg1-cfg3 bits
// - Isolation in lock step with host
// - RSTDRV gives wait-for-key, card number zero
// - Key match moves wait-for-key to sleep
package pnpcf_pkg;

   // ==========================================================================
   // Register indices (byte address is four times the index)
   localparam logic [7:0] IDX_CFG_CTRL   = 8'h02;
   localparam logic [7:0] IDX_WAKE       = 8'h03;
   localparam logic [7:0] IDX_CSN        = 8'h06;
   localparam logic [7:0] IDX_ACTIVATE   = 8'h30;
   localparam logic [7:0] IDX_IO_BASE_HI = 8'h60;
   localparam logic [7:0] IDX_IO_BASE_LO = 8'h61;
   localparam logic [7:0] IDX_IRQ_LEVEL  = 8'h70;
   localparam logic [7:0] IDX_DMA_SEL0   = 8'h74;
   localparam logic [7:0] IDX_DMA_SEL1   = 8'h75;
   localparam logic [7:0] IDX_KEY_PORT   = 8'h80;
   localparam logic [7:0] IDX_COMMAND    = 8'h81;
   localparam logic [7:0] IDX_STATUS     = 8'h82;
   localparam logic [7:0] IDX_CFG0       = 8'hf0;
   localparam logic [7:0] IDX_CFG1       = 8'hf1;
   localparam logic [7:0] IDX_CFG2       = 8'hf2;
   localparam logic [7:0] IDX_CFG3       = 8'hf3;
   localparam logic [7:0] IDX_UNUSED_F4  = 8'hf4;
   localparam logic [7:0] IDX_SAVED_CSN  = 8'hf5;
   localparam logic [7:0] IDX_VENDOR_CTL = 8'hf6;

   // ==========================================================================
   // Field positions and fixed values
   localparam logic [7:0] DMA_NONE_VALUE   = 8'h04;
   localparam int         VCTL_CLEAR_BIT   = 2;
   localparam int         CCTL_RESET_CSN   = 2;
   localparam int         CCTL_WAIT_KEY    = 1;
   localparam int         CMD_AUTOLOAD_BIT = 0;
   localparam int         CFG0_JP_BIT      = 3;
   localparam int         CFG0_PLUG_PLAY_STRAP_BIT   = 2;
   localparam int         CFG1_INTERRUPT_OUTPUT_ENABLE_BIT   = 7;
   localparam int         CFG2_BOOT_ROM_DISABLE_BIT   = 5;
   localparam int         CFG3_PNP_BIT     = 7;
   localparam int         CFG3_SLEEP_BIT   = 2;
   localparam int         CFG3_INACTIVE_AT_POWERUP_BIT_BIT = 0;
   localparam logic [7:0] IO_HI_MASK       = 8'h03;
   localparam logic [7:0] IO_LO_MASK       = 8'he0;
   localparam logic [7:0] ZERO_BYTE        = 8'h00;
   localparam logic [4:0] KEY_LAST         = 5'h1f;

   // ==========================================================================
   // Modes and card states, Gray coded along the usual path
   typedef enum logic [1:0] {
      MODE_JUMPER = 2'b00,
      MODE_PNP    = 2'b01,
      MODE_EEPROM = 2'b11
   } pnpcf_mode_t;

   typedef enum logic [1:0] {
      ST_WAIT_KEY = 2'b00,
      ST_SLEEP    = 2'b01,
      ST_ISOLATE  = 2'b11,
      ST_CONFIG   = 2'b10
   } pnpcf_state_t;

   // ==========================================================================
   // Initiation keys, first byte at entry 0
   localparam logic [0:31][7:0] STD_KEY = {
      8'h6a, 8'hb5, 8'hda, 8'hed, 8'hf6, 8'hfb, 8'h7d, 8'hbe,
      8'hdf, 8'h6f, 8'h37, 8'h1b, 8'h0d, 8'h86, 8'hc3, 8'h61,
      8'hb0, 8'h58, 8'h2c, 8'h16, 8'h8b, 8'h45, 8'ha2, 8'hd1,
      8'he8, 8'h74, 8'h3a, 8'h9d, 8'hce, 8'he7, 8'h73, 8'h39};
   localparam logic [0:31][7:0] VENDOR_KEY = {
      8'hda, 8'h6d, 8'h36, 8'h1b, 8'h8d, 8'h46, 8'h23, 8'h91,
      8'h48, 8'ha4, 8'hd2, 8'h69, 8'h34, 8'h9a, 8'h4d, 8'h26,
      8'h13, 8'h89, 8'h44, 8'ha2, 8'h51, 8'h28, 8'h94, 8'hca,
      8'h65, 8'h32, 8'h19, 8'h0c, 8'h86, 8'h43, 8'ha1, 8'h50};

endpackage

// ===== logic/pnpcf_key_match.sv
// Initiation key matcher: tracks progress through one 32-byte key
`timescale 1ns/1ps
module pnpcf_key_match #(
   parameter logic [0:31][7:0] KEY = pnpcf_pkg::STD_KEY
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Key port writes
   input  wire logic       enable,
   input  wire logic       keyStrobe,
   input  wire logic [7:0] keyData,
   // Result
   output logic            matched
);
   import pnpcf_pkg::*;

   // ==========================================================================
   // Progress decode
   logic [4:0] progress;
   logic [4:0] next_progress;
   logic       next_matched;
   wire  logic hit  = keyStrobe && enable && (keyData == KEY[progress]);
   wire  logic last = (progress == KEY_LAST);

   // Advance on a matching byte, restart on any other byte
   always_comb begin
      next_progress = progress;
      next_matched  = 1'b0;
      if (keyStrobe) begin
         if (hit && last) begin
            next_progress = 5'h00;
            next_matched  = 1'b1;
         end else if (hit) begin
            next_progress = progress + 5'h01;
         end else begin
            next_progress = 5'h00;
         end
      end
   end

   // Progress and one-cycle match pulse
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         progress <= 5'h00;
         matched  <= 1'b0;
      end else begin
         progress <= next_progress;
         matched  <= next_matched;
      end
   end

endmodule // pnpcf_key_match

// ===== bench/pnpcf_checker.sv
// Concurrent checks on the configuration loader ports
`timescale 1ns/1ps
module pnpcf_checker (
   // Clock, reset and bus
   input wire logic [9:0]  avsAddress,
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        avsRead,
   input wire logic        avsWrite,
   input wire logic [31:0] avsWritedata,
   input wire logic [31:0] avsReaddata,
   input wire logic        avsWaitrequest,
   // Straps and state
   input wire logic        jumperStrap,
   input wire logic        plugPlayStrap,
   input wire logic        eepromPlugPlayFlag,
   input wire logic [7:0]  cfg0,
   input wire logic [7:0]  cfg1,
   input wire logic [7:0]  cfg3,
   input wire logic [7:0]  cardSelectNumber,
   input wire logic [7:0]  savedCardNumber,
   input wire pnpcf_pkg::pnpcf_state_t pnpState,
   input wire pnpcf_pkg::pnpcf_mode_t  configMode,
   input wire logic        portsEnabled
);
   import pnpcf_pkg::*;
   // ==========================================================================
   // Sequences: a completed read in config state, a committed clear
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence cfgRead(idx);
      avsRead && avsWaitrequest && avsAddress[9:2] == idx && pnpState == ST_CONFIG
      ##1 !avsWaitrequest;
   endsequence
   sequence vendorClear;
      avsWrite && !avsWaitrequest && avsAddress[9:2] == IDX_VENDOR_CTL && avsWritedata[2]
      && pnpState == ST_CONFIG;
   endsequence
   // ==========================================================================
   // Assertions
   dma_fixed_a: assert property (
      cfgRead(IDX_DMA_SEL0) or cfgRead(IDX_DMA_SEL1) |-> avsReaddata[7:0] == DMA_NONE_VALUE)
      else $error("dma index read wrong");
   mirror_live_a: assert property (cfgRead(IDX_CFG1) |-> avsReaddata[7:0] == cfg1)
      else $error("cfg1 mirror wrong");
   saved_mirror_a: assert property (
      cfgRead(IDX_SAVED_CSN) |-> avsReaddata[7:0] == savedCardNumber)
      else $error("saved number mirror wrong");
   unused_zero_a: assert property (cfgRead(IDX_UNUSED_F4) |-> avsReaddata == 32'h00000000)
      else $error("unused index not zero");
   clear_keeps_saved_a: assert property (
      vendorClear |-> ##[1:2] (cardSelectNumber == 8'h00 && $stable(savedCardNumber)))
      else $error("vendor clear wrong");
   mode_decode_a: assert property ($past(sys_rst) && !sys_rst |=> configMode ==
      (jumperStrap ? MODE_JUMPER : (plugPlayStrap || eepromPlugPlayFlag) ? MODE_PNP : MODE_EEPROM))
      else $error("mode decode wrong");
   strap_flags_a: assert property (!$past(sys_rst) |->
      cfg0[3:2] == $past({jumperStrap, plugPlayStrap}) && cfg3[7] == (configMode == MODE_PNP))
      else $error("cfg0 or cfg3 flags wrong");
   reset_state_a: assert property ($past(sys_rst) && !sys_rst |->
      pnpState == ST_WAIT_KEY && cardSelectNumber == 8'h00)
      else $error("reset state wrong");
   key_to_sleep_a: assert property (
      $past(pnpState) == ST_WAIT_KEY && pnpState != ST_WAIT_KEY |-> pnpState == ST_SLEEP)
      else $error("left wait-key not to sleep");
   ports_quiet_a: assert property (pnpState == ST_WAIT_KEY [*2] |-> !portsEnabled)
      else $error("ports open in wait-key");
   single_wait_a: assert property (!avsWaitrequest |=> avsWaitrequest)
      else $error("waitrequest low too long");
endmodule // pnpcf_checker

bind pnpcf_config_loader pnpcf_checker chk_u (.clk(clk), .sys_rst(sys_rst),
   .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
   .avsWritedata(avsWritedata), .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
   .jumperStrap(jumperStrap), .plugPlayStrap(plugPlayStrap),
   .eepromPlugPlayFlag(eepromPlugPlayFlag), .cfg0(cfg0), .cfg1(cfg1), .cfg3(cfg3),
   .cardSelectNumber(cardSelectNumber), .savedCardNumber(savedCardNumber),
   .pnpState(pnpState), .configMode(configMode), .portsEnabled(portsEnabled));

// ===== bench/pnpcf_host_model.sv
// Host side model: Avalon master cycles and initiation key writes
`timescale 1ns/1ps
module pnpcf_host_model (
   // Clock
   input  wire logic        clk,
   // Avalon master
   output logic      [9:0]  avsAddress,
   output logic             avsRead,
   output logic             avsWrite,
   output logic      [31:0] avsWritedata,
   input  wire logic [31:0] avsReaddata,
   input  wire logic        avsWaitrequest
);
   import pnpcf_pkg::*;
   // ==========================================================================
   // Idle bus at time zero
   initial begin
      avsAddress = 10'h000;
      avsRead = 1'b0;
      avsWrite = 1'b0;
      avsWritedata = 32'h00000000;
   end
   // One transfer, held until waitrequest is sampled low; no fixed latency assumed
   task automatic busCycle(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                           output logic [7:0] rd);
      @(posedge clk);
      avsAddress <= {idx, 2'b00};
      avsRead <= ~wr;
      avsWrite <= wr;
      avsWritedata <= {24'h000000, wd};
      do @(posedge clk); while (avsWaitrequest !== 1'b0);
      rd = avsReaddata[7:0];
      avsRead <= 1'b0;
      avsWrite <= 1'b0;
      avsWritedata <= ~avsWritedata; // Stale data must never pass for live data
   endtask
   // Thirty-two key port writes; one byte is spoiled when asked
   task automatic sendKey(input logic vendor, input int badAt);
      logic [7:0] kb;
      logic [7:0] unused;
      for (int i = 0; i < 32; i++) begin
         kb = vendor ? VENDOR_KEY[i] : STD_KEY[i];
         if (i == badAt) kb = ~kb;
         busCycle(1'b1, IDX_KEY_PORT, kb, unused);
      end
   endtask
endmodule // pnpcf_host_model

// ===== bench/test_pnp_config_mode_and_key_detect.sv
// Self-checking bench for the configuration loader
`timescale 1ns/1ps
module test_pnp_config_mode_and_key_detect;
   import pnpcf_pkg::*;
   // ==========================================================================
   // Signals; image values differ per source so a wrong source shows
   logic clk = 1'b0, sys_rst = 1'b1, jumperStrap = 1'b1, plugPlayStrap = 1'b0, eFlag = 1'b0;
   logic [9:0]  avsAddress;
   logic        avsRead, avsWrite, avsWaitrequest, deviceActive, portsEnabled, p;
   logic [31:0] avsWritedata, avsReaddata;
   logic [7:0]  cfg0, cfg1, cfg2, cfg3, cardSelectNumber, savedCardNumber, rd;
   pnpcf_state_t pnpState;
   pnpcf_mode_t  configMode;
   int          errors = 0, samplesChecked = 0;
   // Rows: jumper strap, plug-play strap, EEPROM flag, expected mode
   logic [4:0]  rows [5] = '{5'b100_00, 5'b111_00, 5'b010_01, 5'b001_01, 5'b000_11};
   logic [7:0]  rIdx [10] = '{8'h74, 8'h75, 8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5, 8'hf6, 8'h20};
   logic [7:0]  rExp [10] = '{8'h04, 8'h04, 8'h00, 8'hda, 8'h97, 8'h72, 8'h00, 8'h05, 8'h00, 8'h00};
   logic [7:0]  rMsk [10] = '{8'hff, 8'hff, 8'h0c, 8'hff, 8'hff, 8'hf7, 8'hff, 8'hff, 8'hff, 8'hff};
   always #2 clk = ~clk;
   pnpcf_host_model host_u (.clk(clk), .avsAddress(avsAddress), .avsRead(avsRead),
      .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
      .avsWaitrequest(avsWaitrequest));
   pnpcf_config_loader dut_u (.clk(clk), .sys_rst(sys_rst), .avsAddress(avsAddress),
      .avsRead(avsRead), .avsWrite(avsWrite), .avsWritedata(avsWritedata),
      .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .jumperStrap(jumperStrap),
      .plugPlayStrap(plugPlayStrap), .jumperCfg1(7'h25), .jumperCfg2(8'h3c),
      .eepromPlugPlayFlag(eFlag), .eepromCfg1(7'h5a), .eepromCfg2(8'hb7), .eepromCfg3(7'h7f),
      .cfg0(cfg0), .cfg1(cfg1), .cfg2(cfg2), .cfg3(cfg3), .cardSelectNumber(cardSelectNumber),
      .savedCardNumber(savedCardNumber), .deviceActive(deviceActive), .pnpState(pnpState),
      .configMode(configMode), .portsEnabled(portsEnabled));
   // ==========================================================================
   // Shared tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic report_and_stop();
      if (errors == 0 && samplesChecked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input int n);
      host_u.busCycle(1'b1, idx, d, rd);
      repeat (n) @(posedge clk);
   endtask
   task automatic key(input logic v, input int bad, input pnpcf_state_t exp);
      host_u.sendKey(v, bad);
      repeat (3) @(posedge clk);
      check({6'h00, pnpState}, {6'h00, exp});
   endtask
   // ==========================================================================
   // Mode rows, then the config-state cases in the last mode
   initial begin
      for (int r = 0; r < 5; r++) begin
         @(posedge clk);
         sys_rst <= 1'b1;
         {jumperStrap, plugPlayStrap, eFlag} <= rows[r][4:2];
         repeat (4) @(posedge clk);
         sys_rst <= 1'b0;
         repeat (3) @(posedge clk);
         p = rows[r][1:0] == 2'b01;
         check({6'h00, configMode}, {6'h00, rows[r][1:0]});
         check(cfg0 & 8'h0c, {4'h0, rows[r][4:3], 2'b00});
         check(cfg1, {~p, rows[r][4] ? 7'h25 : 7'h5a});
         check(cfg2, rows[r][4] ? 8'h1c : 8'h97);
         check(cfg3 & 8'hf7, p ? 8'hf3 : 8'h72);
         check({cardSelectNumber[5:0], pnpState}, 8'h00);
         if (!rows[r][4]) check({7'h00, deviceActive}, {7'h00, ~p});
         host_u.busCycle(1'b0, IDX_CFG1, 8'h00, rd);
         check(rd, 8'h00);
         key(1'b0, 32, p ? ST_SLEEP : ST_WAIT_KEY);
         key(1'b1, 9, p ? ST_SLEEP : ST_WAIT_KEY);
         key(1'b1, 32, ST_SLEEP);
         check({7'h00, portsEnabled}, 8'h01);
      end
      wr(IDX_WAKE, 8'h00, 2);
      check({6'h00, pnpState}, {6'h00, ST_ISOLATE});
      wr(IDX_CSN, 8'h05, 2);
      check({6'h00, pnpState}, {6'h00, ST_CONFIG});
      for (int i = 0; i < 10; i++) begin
         host_u.busCycle(1'b0, rIdx[i], 8'h00, rd);
         check(rd & rMsk[i], rExp[i]);
      end
      wr(IDX_VENDOR_CTL, 8'h04, 2);
      check(cardSelectNumber, 8'h00);
      check(savedCardNumber, 8'h05);
      wr(IDX_IRQ_LEVEL, 8'h03, 2);
      check(cfg1, 8'hba);
      wr(IDX_ACTIVATE, 8'h00, 2);
      check({7'h00, deviceActive}, 8'h00);
      wr(IDX_IO_BASE_LO, 8'h60, 2);
      check(cfg1, 8'hbb);
      wr(IDX_COMMAND, 8'h01, 3);
      check(cfg1, 8'hda);
      check(cfg2, 8'h97);
      wr(IDX_CFG_CTRL, 8'h02, 2);
      check({7'h00, portsEnabled}, 8'h00);
      report_and_stop();
   end
   // Watchdog: the run needs a few thousand cycles at most
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      report_and_stop();
   end
endmodule // test_pnp_config_mode_and_key_detect
